// file: core/spi_cfg.svh
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH

// ------------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------------
`define CTL_IRQ_EN      7
`define CTL_ENABLE      6
`define CTL_LSB_FIRST   5
`define CTL_MASTER      4
`define CTL_RATE_HI     1
`define CTL_RATE_LO     0
`define CTL_RESET       8'h00

// ------------------------------------------------------------------
// Status register field positions
// ------------------------------------------------------------------
`define ST_DONE         7
`define ST_WCOL         6
`define ST_DOUBLE       0
`define ST_RESET        8'h00

// ------------------------------------------------------------------
// Pin direction request bits
// ------------------------------------------------------------------
`define DIR_MOSI        3
`define DIR_MISO        2
`define DIR_SCK         1
`define DIR_SS          0

// ------------------------------------------------------------------
// Half periods of the master clock in system clocks, and the index of the last bit
// ------------------------------------------------------------------
`define HALF_DIV4       7'h02
`define HALF_DIV16      7'h08
`define HALF_DIV64      7'h20
`define HALF_DIV128     7'h40
`define HALF_DIV2       7'h01
`define HALF_DIV8       7'h04
`define HALF_DIV32      7'h10
`define FAR_HALF        7'h08
`define BITS_LAST       4'h7

`endif

// file: core/spi_far_end.sv
`timescale 1ns/100ps
`include "spi_cfg.svh"
module spi_far_end (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // User side
  input  wire logic           role_master,
  input  wire logic           lsb_first,
  input  wire logic           tx_load,
  input  wire spi_pkg::byte_t tx_byte,
  output logic                busy,
  output spi_pkg::byte_t      rx_byte,
  output logic                rx_valid,
  // Serial link
  spi_link_if.far             link
);
  import spi_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] sck_s;
  logic [1:0] mosi_s;
  logic [1:0] miso_s;
  logic [1:0] ss_s;
  logic       sck_d;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_s  <= 2'b00;
      mosi_s <= 2'b00;
      miso_s <= 2'b00;
      ss_s   <= 2'b11;
      sck_d  <= 1'b0;
    end else begin
      sck_s  <= {sck_s[0], link.sck};
      mosi_s <= {mosi_s[0], link.mosi};
      miso_s <= {miso_s[0], link.miso};
      ss_s   <= {ss_s[0], link.ss_n};
      sck_d  <= sck_s[1];
    end
  end

  // ------------------------------------------------------------------
  // Events
  // ------------------------------------------------------------------
  far_e       state_r;
  logic [6:0] div_r;
  logic [3:0] bits_r;
  byte_t      shift_r;
  byte_t      shifted;
  logic       in_bit_r;
  logic       sck_o_r;
  logic       slv_act;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       last;

  assign slv_act = ~role_master & ~ss_s[1];
  assign tick    = (state_r != fe_idle) & (div_r == `FAR_HALF - 7'h01);
  assign rise    = role_master ? (state_r == fe_shift) & tick & ~sck_o_r
                               : slv_act & sck_s[1] & ~sck_d;
  assign fall    = role_master ? (state_r == fe_shift) & tick & sck_o_r
                               : slv_act & ~sck_s[1] & sck_d;
  assign shifted = lsb_first ? {in_bit_r, shift_r[7:1]} : {shift_r[6:0], in_bit_r};
  assign last    = fall & (bits_r == `BITS_LAST);

  // ------------------------------------------------------------------
  // Master sequence: select, eight bits, release
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= fe_idle;
    end else begin
      case (state_r)
        fe_idle: begin
          if (role_master & tx_load) begin
            state_r <= fe_sel;
          end
        end
        fe_sel: begin
          if (tick) begin
            state_r <= fe_shift;
          end
        end
        fe_shift: begin
          if (last) begin
            state_r <= fe_desel;
          end
        end
        fe_desel: begin
          if (tick) begin
            state_r <= fe_idle;
          end
        end
        default: state_r <= fe_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r   <= 7'h00;
      sck_o_r <= 1'b0;
    end else if (state_r == fe_idle || tick || last) begin
      div_r   <= 7'h00;
      sck_o_r <= (state_r == fe_shift) & tick & ~sck_o_r;
    end else begin
      div_r   <= div_r + 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // Shifter
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bits_r <= 4'h0;
    end else if (last || !(slv_act || state_r == fe_shift)) begin
      bits_r <= 4'h0;
    end else if (fall) begin
      bits_r <= bits_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_bit_r <= 1'b0;
    end else if (rise) begin
      in_bit_r <= role_master ? miso_s[1] : mosi_s[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= 8'h00;
    end else if (tx_load && state_r == fe_idle && bits_r == 4'h0) begin
      shift_r <= tx_byte;
    end else if (fall) begin
      shift_r <= shifted;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
      busy     <= 1'b0;
    end else begin
      rx_valid <= last;
      if (last) begin
        rx_byte <= shifted;
      end
      busy <= (state_r != fe_idle) | (role_master & tx_load) | (bits_r != 4'h0);
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.far_sck_o   <= 1'b0;
      link.far_sck_oe  <= 1'b0;
      link.far_mosi_o  <= 1'b0;
      link.far_mosi_oe <= 1'b0;
      link.far_miso_o  <= 1'b0;
      link.far_miso_oe <= 1'b0;
      link.far_ss_o    <= 1'b1;
      link.far_ss_oe   <= 1'b0;
    end else begin
      link.far_sck_o   <= sck_o_r;
      link.far_sck_oe  <= role_master;
      link.far_mosi_o  <= lsb_first ? shift_r[0] : shift_r[7];
      link.far_mosi_oe <= role_master;
      link.far_miso_o  <= lsb_first ? shift_r[0] : shift_r[7];
      link.far_miso_oe <= slv_act;
      // Select is released after every byte so the slave counter resyncs.
      link.far_ss_o    <= (state_r == fe_idle);
      link.far_ss_oe   <= role_master;
    end
  end
endmodule : spi_far_end

// file: core/spi_link_if.sv
`timescale 1ns/100ps
interface spi_link_if;
  logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
  logic dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
  logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe;
  logic far_miso_o, far_miso_oe, far_ss_o, far_ss_oe;
  logic sck, mosi, miso, ss_n;

  // Select and data lines rest high when undriven, as with a pull-up. The clock rests
  // low, its idle level in this mode, so releasing it never makes a false edge.
  assign sck  = dev_sck_oe  ? dev_sck_o  : (far_sck_oe  ? far_sck_o  : 1'b0);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : 1'b1);
  assign ss_n = dev_ss_oe   ? dev_ss_o   : (far_ss_oe   ? far_ss_o   : 1'b1);

  modport dev (
    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
    output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
    input  sck, mosi, miso, ss_n
  );
  modport far (
    output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe,
    output far_miso_o, far_miso_oe, far_ss_o, far_ss_oe,
    input  sck, mosi, miso, ss_n
  );
endinterface : spi_link_if

// file: core/spi_pkg.sv
package spi_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic {
    st_idle,
    st_shift
  } xfer_e;
  typedef enum logic [1:0] {
    fe_idle,
    fe_sel,
    fe_shift,
    fe_desel
  } far_e;
endpackage : spi_pkg

// file: core/spi_port_dev.sv
`timescale 1ns/100ps
`include "spi_cfg.svh"
module spi_port_dev (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Software access
  input  wire logic          ctrl_wr,
  input  wire spi_pkg::byte_t ctrl_wdata,
  input  wire logic          status_wr,
  input  wire spi_pkg::byte_t status_wdata,
  input  wire logic          data_wr,
  input  wire spi_pkg::byte_t data_wdata,
  input  wire logic          data_rd,
  // Pin direction requests and select output level
  input  wire logic [3:0]    pin_dir,
  input  wire logic          ss_level,
  // Readback and interrupt
  output spi_pkg::byte_t     port_control_register,
  output spi_pkg::byte_t     port_status_register,
  output spi_pkg::byte_t     port_data_register,
  output logic               irq,
  // Serial link
  spi_link_if.dev            link
);
  import spi_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] sck_s;
  logic [1:0] mosi_s;
  logic [1:0] miso_s;
  logic [1:0] ss_s;
  logic       sck_d;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_s  <= 2'b00;
      mosi_s <= 2'b00;
      miso_s <= 2'b00;
      ss_s   <= 2'b11;
      sck_d  <= 1'b0;
    end else begin
      sck_s  <= {sck_s[0], link.sck};
      mosi_s <= {mosi_s[0], link.mosi};
      miso_s <= {miso_s[0], link.miso};
      ss_s   <= {ss_s[0], link.ss_n};
      sck_d  <= sck_s[1];
    end
  end

  // ------------------------------------------------------------------
  // Mode decode and event terms
  // ------------------------------------------------------------------
  xfer_e      state_r;
  logic [6:0] div_r;
  logic [6:0] half;
  logic [3:0] bits_r;
  byte_t      shift_r;
  byte_t      shifted;
  logic       in_bit_r;
  logic       sck_o_r;
  logic       en;
  logic       master;
  logic       lsbf;
  logic       mode_fault;
  logic       slv_act;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       last;
  logic       can_load;
  logic       load;
  logic       wcol_ev;
  logic       done_nxt;
  byte_t      ctrl_nxt;

  assign en         = port_control_register[`CTL_ENABLE];
  assign master     = port_control_register[`CTL_MASTER];
  assign lsbf       = port_control_register[`CTL_LSB_FIRST];
  assign mode_fault = en & master & ~pin_dir[`DIR_SS] & ~ss_s[1];
  assign slv_act    = en & ~master & ~ss_s[1];
  assign tick       = (state_r == st_shift) & (div_r == half - 7'h01);
  // In slave mode edges come from the sampled pin, so the far clock is
  // limited to a quarter of clk or edges get lost.
  assign rise = master ? (tick & ~sck_o_r) : (slv_act & sck_s[1] & ~sck_d);
  assign fall = master ? (tick & sck_o_r) : (slv_act & ~sck_s[1] & sck_d);
  assign shifted  = lsbf ? {in_bit_r, shift_r[7:1]} : {shift_r[6:0], in_bit_r};
  assign last     = fall & (bits_r == `BITS_LAST);
  assign can_load = master ? (state_r == st_idle) : (bits_r == 4'h0);
  assign load     = en & data_wr & can_load;
  assign wcol_ev  = en & data_wr & ~can_load;
  assign done_nxt = last | mode_fault
                  | (port_status_register[`ST_DONE] & ~data_rd);

  always_comb begin
    ctrl_nxt = ctrl_wr ? ctrl_wdata : port_control_register;
    if (mode_fault) begin
      ctrl_nxt[`CTL_MASTER] = 1'b0;
    end
  end

  // Seven distinct rates; double speed with the slowest code repeats /64.
  always_comb begin
    case ({port_status_register[`ST_DOUBLE],
           port_control_register[`CTL_RATE_HI:`CTL_RATE_LO]})
      3'b000:  half = `HALF_DIV4;
      3'b001:  half = `HALF_DIV16;
      3'b010:  half = `HALF_DIV64;
      3'b011:  half = `HALF_DIV128;
      3'b100:  half = `HALF_DIV2;
      3'b101:  half = `HALF_DIV8;
      3'b110:  half = `HALF_DIV32;
      3'b111:  half = `HALF_DIV64;
      default: half = `HALF_DIV4;
    endcase
  end

  // ------------------------------------------------------------------
  // Registers seen by software
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_control_register <= `CTL_RESET;
    end else begin
      port_control_register <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_status_register <= `ST_RESET;
    end else begin
      port_status_register[`ST_DONE] <= done_nxt;
      port_status_register[`ST_WCOL] <= wcol_ev
                                      | (port_status_register[`ST_WCOL] & ~data_rd);
      if (status_wr) begin
        port_status_register[`ST_DOUBLE] <= status_wdata[`ST_DOUBLE];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_data_register <= 8'h00;
    end else if (last) begin
      port_data_register <= shifted;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= done_nxt & ctrl_nxt[`CTL_IRQ_EN];
    end
  end

  // ------------------------------------------------------------------
  // Master clock generator
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: begin
          if (load & master & ~mode_fault) begin
            state_r <= st_shift;
          end
        end
        st_shift: begin
          if (last | mode_fault | ~en | ~master) begin
            state_r <= st_idle;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r   <= 7'h00;
      sck_o_r <= 1'b0;
    end else if (state_r != st_shift || last) begin
      div_r   <= 7'h00;
      sck_o_r <= 1'b0;
    end else if (tick) begin
      div_r   <= 7'h00;
      sck_o_r <= ~sck_o_r;
    end else begin
      div_r   <= div_r + 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // Shift register and bit counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bits_r <= 4'h0;
    end else if (load || last || !(slv_act || state_r == st_shift)) begin
      bits_r <= 4'h0;
    end else if (fall) begin
      bits_r <= bits_r + 4'h1;
    end
  end

  // Sample on the rising edge, shift on the falling one, so the line
  // never changes while the far end is still sampling it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_bit_r <= 1'b0;
    end else if (rise) begin
      in_bit_r <= master ? miso_s[1] : mosi_s[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= 8'h00;
    end else if (load) begin
      shift_r <= data_wdata;
    end else if (fall) begin
      shift_r <= shifted;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers and direction overrides
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.dev_sck_o   <= 1'b0;
      link.dev_sck_oe  <= 1'b0;
      link.dev_mosi_o  <= 1'b0;
      link.dev_mosi_oe <= 1'b0;
      link.dev_miso_o  <= 1'b0;
      link.dev_miso_oe <= 1'b0;
      link.dev_ss_o    <= 1'b1;
      link.dev_ss_oe   <= 1'b0;
    end else begin
      link.dev_sck_o   <= sck_o_r;
      link.dev_sck_oe  <= en & master & pin_dir[`DIR_SCK];
      link.dev_mosi_o  <= lsbf ? shift_r[0] : shift_r[7];
      link.dev_mosi_oe <= en & master & pin_dir[`DIR_MOSI];
      link.dev_miso_o  <= lsbf ? shift_r[0] : shift_r[7];
      link.dev_miso_oe <= slv_act & pin_dir[`DIR_MISO];
      link.dev_ss_o    <= ss_level;
      link.dev_ss_oe   <= en & master & pin_dir[`DIR_SS];
    end
  end
endmodule : spi_port_dev

// file: verification/spi_master_slave_port_tb.sv
`timescale 1ns/100ps
module spi_master_slave_port_tb;
  import spi_pkg::*;

  // ----------------------------------------------------------------
  // Master transfer table
  // ----------------------------------------------------------------
  typedef struct packed {
    byte_t      ctl;
    logic       dbl;
    logic [7:0] half;
    byte_t      dtx;
    byte_t      ftx;
    logic       chk;
  } row_s;

  // Rates below sixteen outrun the synchronised far end, so the received bytes are not compared there.
  row_s rows [8] = '{
    '{8'h50, 1'b0, 8'h02, 8'h11, 8'h22, 1'b0},
    '{8'h51, 1'b0, 8'h08, 8'hA5, 8'h3C, 1'b1},
    '{8'h72, 1'b0, 8'h20, 8'h81, 8'h1E, 1'b1},
    '{8'hD3, 1'b0, 8'h40, 8'h5A, 8'hC3, 1'b1},
    '{8'hD0, 1'b1, 8'h01, 8'h44, 8'h77, 1'b0},
    '{8'h51, 1'b1, 8'h04, 8'h12, 8'h34, 1'b0},
    '{8'hF2, 1'b1, 8'h10, 8'h96, 8'h0F, 1'b1},
    '{8'h53, 1'b1, 8'h20, 8'h6B, 8'hE4, 1'b1}
  };

  logic       clk, nrst, ctrl_wr, status_wr, data_wr, data_rd, ss_level;
  logic       irq, role_master, lsb_first, tx_load, busy, rx_valid;
  logic [3:0] pin_dir;
  byte_t      ctrl_wdata, status_wdata, data_wdata, tx_byte, rx_byte, far_got;
  byte_t      ctl_q, st_q, dat_q;
  row_s       r;
  int         failures, cmp_count, n;

  spi_link_if link ();

  spi_port_dev spi_port_dev_inst (.clk(clk), .nrst(nrst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .status_wr(status_wr), .status_wdata(status_wdata),
    .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd), .pin_dir(pin_dir),
    .ss_level(ss_level), .port_control_register(ctl_q), .port_status_register(st_q),
    .port_data_register(dat_q), .irq(irq), .link(link));

  spi_far_end spi_far_end_inst (.clk(clk), .nrst(nrst), .role_master(role_master),
    .lsb_first(lsb_first), .tx_load(tx_load), .tx_byte(tx_byte), .busy(busy),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .link(link));

  spi_port_chk spi_port_chk_inst (.clk(clk), .nrst(nrst), .dev_sck_oe(link.dev_sck_oe),
    .dev_mosi_oe(link.dev_mosi_oe), .dev_miso_oe(link.dev_miso_oe),
    .dev_ss_oe(link.dev_ss_oe), .far_sck_oe(link.far_sck_oe), .sck(link.sck),
    .mosi(link.mosi), .ss_n(link.ss_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The rx_valid strobe is a one-cycle pulse, so the byte is caught on it here.
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      far_got <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic sw(input int k, input byte_t v);
    @(posedge clk);
    ctrl_wr <= k == 0;
    status_wr <= k == 1;
    data_wr <= k == 2;
    data_rd <= k == 3;
    ctrl_wdata <= v;
    status_wdata <= v;
    data_wdata <= v;
    @(posedge clk);
    {ctrl_wr, status_wr, data_wr, data_rd} <= 4'h0;
  endtask : sw

  task automatic far_send(input byte_t v);
    @(posedge clk);
    tx_load <= 1'b1;
    tx_byte <= v;
    @(posedge clk);
    tx_load <= 1'b0;
  endtask : far_send

  task automatic far_byte(input byte_t v, input logic hit);
    far_send(v);
    for (n = 0; n < 400 && link.sck !== 1'b1; n++) @(negedge clk);
    if (hit) begin
      cyc(24);
      sw(2, 8'h00);
    end
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
    check({7'h00, busy}, 8'h00);
    repeat (4) @(negedge clk);
  endtask : far_byte

  task automatic results();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  initial begin
    #300_000;
    failures++;
    results();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, ctrl_wr, status_wr, data_wr, data_rd, role_master, lsb_first, tx_load} = 8'h00;
    {ctrl_wdata, status_wdata, data_wdata, tx_byte} = 32'h0000_0000;
    ss_level = 1'b1;
    pin_dir = 4'h0;
    failures = 0;
    cmp_count = 0;
    cyc(3);
    nrst <= 1'b1;
    cyc(3);
    pin_dir <= 4'hB;
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      r = rows[i];
      lsb_first <= r.ctl[5];
      far_send(r.ftx);
      sw(0, r.ctl);
      sw(1, {7'h00, r.dbl});
      ss_level <= 1'b0;
      cyc(8);
      sw(2, r.dtx);
      for (n = 0; n < 2000 && link.sck !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 200 && link.sck === 1'b1; n++) @(negedge clk);
      check(8'(n), r.half);
      for (n = 0; n < 4000 && st_q[7] !== 1'b1; n++) @(negedge clk);
      check(st_q & 8'h81, {1'b1, 6'h00, r.dbl});
      check({7'h00, irq}, {7'h00, r.ctl[7]});
      // The pin lags the internal clock by one register, so it is judged once settled.
      repeat (8) @(negedge clk);
      check({7'h00, link.sck}, 8'h00);
      cyc(1);
      ss_level <= 1'b1;
      cyc(12);
      if (r.chk) begin
        check(dat_q, r.ftx);
        check(far_got, r.dtx);
      end
      sw(3, 8'h00);
      @(negedge clk);
      check(st_q & 8'h80, 8'h00);
      check({7'h00, irq}, 8'h00);
    end
    cyc(1);
    pin_dir <= 4'h4;
    lsb_first <= 1'b0;
    sw(0, 8'hC0);
    sw(2, 8'hB4);
    role_master <= 1'b1;
    far_byte(8'h69, 1'b0);
    check(dat_q, 8'h69);
    check(st_q & 8'h80, 8'h80);
    check({7'h00, irq}, 8'h01);
    check(far_got, 8'hB4);
    far_byte(8'hD2, 1'b1);
    check(st_q & 8'hC0, 8'hC0);
    check(dat_q, 8'hD2);
    check(far_got, 8'h69);
    sw(3, 8'h00);
    @(negedge clk);
    check(st_q & 8'hC0, 8'h00);
    cyc(1);
    pin_dir <= 4'hA;
    sw(0, 8'h51);
    far_byte(8'h3C, 1'b0);
    check(ctl_q, 8'h41);
    check(st_q & 8'h80, 8'h80);
    cyc(1);
    nrst <= 1'b0;
    cyc(3);
    check(ctl_q | st_q | dat_q, 8'h00);
    check({irq, link.ss_n, link.dev_sck_oe, link.dev_mosi_oe, link.dev_miso_oe,
           link.dev_ss_oe, 2'b00}, 8'h40);
    nrst <= 1'b1;
    cyc(3);
    results();
  end
endmodule : spi_master_slave_port_tb

// file: verification/spi_port_chk.sv
`timescale 1ns/100ps
module spi_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Output enables
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic dev_ss_oe,
  input wire logic far_sck_oe,
  // Resolved lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n
);
  // ----------------------------------------------------------------
  // Clock rises counted within one select frame
  // ----------------------------------------------------------------
  logic [4:0] rise_cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_cnt_r <= 5'h00;
    end else if (ss_n) begin
      rise_cnt_r <= 5'h00;
    end else if ($rose(sck)) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  sequence byte_end;
    dev_sck_oe && $fell(sck) && rise_cnt_r[2:0] == 3'h0 && rise_cnt_r != 5'h00;
  endsequence

  // Select is an input here, so a low level means another master took the link.
  sequence fault_seen;
    dev_sck_oe && !dev_ss_oe && !ss_n;
  endsequence

  a_sck_in_frame: assert property (
    $rose(sck) && (dev_sck_oe || far_sck_oe) |-> !ss_n) else $error("sck rose unselected");
  a_mosi_steady: assert property (
    $rose(sck) && !ss_n |-> $stable(mosi)) else $error("mosi moved at sample edge");
  a_byte_frames: assert property (
    $rose(ss_n) |-> rise_cnt_r[2:0] == 3'h0) else $error("frame not whole bytes");
  a_ss_left_low: assert property (
    byte_end |-> !ss_n [*4]) else $error("select moved by the port");
  a_miso_idle: assert property (
    ss_n [*5] |-> !dev_miso_oe) else $error("miso driven while unselected");
  a_master_miso_in: assert property (
    dev_mosi_oe || dev_sck_oe |-> !dev_miso_oe) else $error("miso driven as master");
  a_slave_ss_in: assert property (
    dev_miso_oe |-> !dev_ss_oe) else $error("select driven as slave");
  a_fault_demote: assert property (
    fault_seen |-> ##[1:6] !dev_sck_oe) else $error("master kept sck on fault");
  a_far_sck_slow: assert property (
    far_sck_oe && !dev_sck_oe && $rose(sck) |=> sck) else $error("far sck too fast");
endmodule : spi_port_chk
